// ===== adc_int_pkg.sv
// Functional notes
// (RL1) Sticky overflow bits: left D3, right D2, barrel shifter D1; reserved read zero.
// (RL2) Sticky bits are read-only, clear on read, set again only on fresh events.
// (RL3) Flag D6 is 1 while left power is below left noise threshold.
// (RL4) Flag D5 is 1 while right power is below right noise threshold.
// (RL5) Flag D4 shows engine standard interrupt, D3 engine auxiliary; reset zero.
// (RL6) Live companion registers share the layout, unaffected by clear-on-read.
// (RL7) Control D4 set lets AGC noise events drive the interrupt pin.
// (RL8) Control D2 set lets engine and overflow events drive the interrupt pin.
// (RL9) Control D1 set lets data-available events drive the interrupt pin.
// (RL10) Control D0 clear: one active-high 2 ms pulse per qualifying event.
// (RL11) Control D0 set: 2 ms pulses every 4 ms until a sticky read.
// (RL12) Host writes only reset values into reserved control bits.
// (RL13) Host never writes reserved locations between the flag registers.
// (RL14) Enabled sources are ORed; any one of them triggers the interrupt pin.
package adc_int_pkg;
   localparam logic [7:0] ADDR_OVF_STICKY = 8'h2A;
   localparam logic [7:0] ADDR_OVF_LIVE = 8'h2B;
   localparam logic [7:0] ADDR_ADC_STICKY = 8'h2D;
   localparam logic [7:0] ADDR_ADC_LIVE = 8'h2F;
   localparam logic [7:0] ADDR_INT_CTRL = 8'h30;
   localparam int OVF_LEFT_BIT = 3;
   localparam int OVF_RIGHT_BIT = 2;
   localparam int OVF_SHIFT_BIT = 1;
   localparam int NOISE_LEFT_BIT = 6;
   localparam int NOISE_RIGHT_BIT = 5;
   localparam int ENG_STD_BIT = 4;
   localparam int ENG_AUX_BIT = 3;
   localparam int CTRL_NOISE_EN_BIT = 4;
   localparam int CTRL_ENG_EN_BIT = 2;
   localparam int CTRL_DAV_EN_BIT = 1;
   localparam int CTRL_REPEAT_BIT = 0;
   localparam logic [7:0] OVF_MASK = 8'h0E;
   localparam logic [7:0] ADC_MASK = 8'h78;
   localparam logic [7:0] NOISE_MASK = 8'h60;
   localparam logic [7:0] ENG_MASK = 8'h18;
   localparam logic [7:0] CTRL_MASK = 8'h17;
   localparam logic [7:0] FLAGS_RESET = 8'h00;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;
   localparam int CLK_FREQ_HZ = 100_000_000;
   localparam int PULSE_TIME_US = 2000;
   localparam int PERIOD_TIME_US = 4000;
   localparam int PULSE_CYCLES_DEF = PULSE_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int PERIOD_CYCLES_DEF = PERIOD_TIME_US * (CLK_FREQ_HZ / 1_000_000);
   localparam int CNT_W = 20;
   typedef enum logic [1:0] {PULSE_IDLE, PULSE_HIGH, PULSE_LOW} pulse_state_t;
endpackage

// ===== sticky_flags.sv
`timescale 1ns/1ps
`default_nettype none
module sticky_flags
   import adc_int_pkg::*;
#(
   parameter logic [7:0] MASK = 8'hFF
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [7:0] src,
   input wire logic clearReq,
   output logic [7:0] stickyOut,
   output logic [7:0] liveOut,
   output logic [7:0] riseOut
);
   typedef struct packed {
      logic [7:0] prev;
      logic [7:0] sticky;
   } flag_state_t;

   flag_state_t stateReg;
   flag_state_t stateNext;

   // a fresh rising edge sets the flag; it wins over a clear in the same cycle
   always_comb begin
      stateNext = stateReg;
      riseOut = src & ~stateReg.prev & MASK;
      stateNext.prev = src & MASK;
      stateNext.sticky = (clearReq ? FLAGS_RESET : stateReg.sticky) | riseOut; // RL2
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stateReg <= '{prev: FLAGS_RESET, sticky: FLAGS_RESET};
      end else if (clkEn) begin
         stateReg <= stateNext;
      end
   end

   assign stickyOut = stateReg.sticky;
   assign liveOut = stateReg.prev; // RL6

   set_beats_clear_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      clkEn && (riseOut != 8'h00) |=> (stickyOut & $past(riseOut)) == $past(riseOut))
      else $error("fresh event lost from sticky flag");
   clear_on_read_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      clkEn && clearReq && (riseOut == 8'h00) |=> stickyOut == 8'h00)
      else $error("sticky flags not cleared by read");
endmodule
`default_nettype wire

// ===== int_pulse_gen.sv
`timescale 1ns/1ps
`default_nettype none
module int_pulse_gen
   import adc_int_pkg::*;
#(
   parameter int unsigned PULSE_CYCLES = PULSE_CYCLES_DEF,
   parameter int unsigned PERIOD_CYCLES = PERIOD_CYCLES_DEF
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic trigger,
   input wire logic repeatMode,
   input wire logic stopReq,
   output logic pulseOut
);
   localparam logic [CNT_W-1:0] HIGH_LAST = CNT_W'(PULSE_CYCLES - 1);
   localparam logic [CNT_W-1:0] PERIOD_LAST = CNT_W'(PERIOD_CYCLES - 1);

   typedef struct packed {
      pulse_state_t state;
      logic [CNT_W-1:0] cnt;
      logic stopPend;
      logic out;
   } pulse_reg_t;

   pulse_reg_t pulseReg;
   pulse_reg_t pulseNext;

   // the current pulse always runs its full width, so a read never chops it short
   always_comb begin
      pulseNext = pulseReg;
      case (pulseReg.state)
         PULSE_IDLE: begin
            if (trigger) begin
               pulseNext.state = PULSE_HIGH;
               pulseNext.cnt = '0;
               pulseNext.out = 1'b1;
               pulseNext.stopPend = 1'b0;
            end
         end
         PULSE_HIGH: begin
            pulseNext.cnt = pulseReg.cnt + 1'b1;
            pulseNext.stopPend = (pulseReg.stopPend | stopReq) & ~trigger;
            if (pulseReg.cnt == HIGH_LAST) begin // RL10
               pulseNext.out = 1'b0;
               if (repeatMode && !pulseNext.stopPend) begin // RL11
                  pulseNext.state = PULSE_LOW;
               end else begin
                  pulseNext.state = PULSE_IDLE;
                  pulseNext.cnt = '0;
               end
            end
         end
         PULSE_LOW: begin
            pulseNext.cnt = pulseReg.cnt + 1'b1;
            if (stopReq && !trigger) begin // RL11
               pulseNext.state = PULSE_IDLE;
               pulseNext.cnt = '0;
            end else if (pulseReg.cnt == PERIOD_LAST) begin
               pulseNext.state = PULSE_HIGH;
               pulseNext.cnt = '0;
               pulseNext.out = 1'b1;
            end
         end
         default: begin
            pulseNext.state = PULSE_IDLE;
            pulseNext.out = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pulseReg <= '{state: PULSE_IDLE, cnt: '0, stopPend: 1'b0, out: 1'b0};
      end else if (clkEn) begin
         pulseReg <= pulseNext;
      end
   end

   assign pulseOut = pulseReg.out;

   pulse_width_a: assert property (@(posedge clk_sys) disable iff (reset) // RL10
      $fell(pulseOut) |-> $past(pulseReg.cnt) == HIGH_LAST)
      else $error("interrupt pulse width wrong");
   pulse_period_a: assert property (@(posedge clk_sys) disable iff (reset) // RL11
      $rose(pulseOut) && $past(pulseReg.state) == PULSE_LOW |-> $past(pulseReg.cnt) == PERIOD_LAST)
      else $error("interrupt pulse period wrong");
   pulse_start_a: assert property (@(posedge clk_sys) disable iff (reset) // RL14
      clkEn && trigger && pulseReg.state == PULSE_IDLE |=> pulseOut)
      else $error("trigger did not start a pulse");
   single_shot_a: assert property (@(posedge clk_sys) disable iff (reset) // RL10
      clkEn && $fell(pulseOut) && !$past(repeatMode) |-> pulseReg.state == PULSE_IDLE)
      else $error("single mode pulse repeated");
endmodule
`default_nettype wire

// ===== adc_interrupt_flags_first_interrupt_pin.sv
`timescale 1ns/1ps
`default_nettype none
module adc_interrupt_flags_first_interrupt_pin #(
   parameter int unsigned PULSE_CYCLES = adc_int_pkg::PULSE_CYCLES_DEF,
   parameter int unsigned PERIOD_CYCLES = adc_int_pkg::PERIOD_CYCLES_DEF
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clkEn,
   input wire logic [7:0] regAddr,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [7:0] regWdata,
   output logic [7:0] regRdata,
   output logic regRdValid,
   input wire logic ovfLeft,
   input wire logic ovfRight,
   input wire logic ovfShifter,
   input wire logic noiseLeft,
   input wire logic noiseRight,
   input wire logic engineStdInt,
   input wire logic engineAuxInt,
   input wire logic dataAvail,
   output logic firstInterruptPin
);
   import adc_int_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] rdData;
      logic rdValid;
   } top_reg_t;

   top_reg_t topReg;
   top_reg_t topNext;

   logic [7:0] ovfSrc;
   logic [7:0] adcSrc;
   logic [7:0] ovfSticky;
   logic [7:0] ovfLive;
   logic [7:0] ovfRise;
   logic [7:0] adcSticky;
   logic [7:0] adcLive;
   logic [7:0] adcRise;
   logic ovfClear;
   logic adcClear;
   logic intEvent;
   logic pulseOut;

   // a strobe aimed at one register
   function automatic logic regHit(input logic [7:0] addr, input logic [7:0] target, input logic strobe);
      regHit = strobe && (addr == target);
   endfunction

   // gather the source levels into their register layout
   always_comb begin
      ovfSrc = FLAGS_RESET;
      ovfSrc[OVF_LEFT_BIT] = ovfLeft; // RL1
      ovfSrc[OVF_RIGHT_BIT] = ovfRight; // RL1
      ovfSrc[OVF_SHIFT_BIT] = ovfShifter; // RL1
      adcSrc = FLAGS_RESET;
      adcSrc[NOISE_LEFT_BIT] = noiseLeft; // RL3
      adcSrc[NOISE_RIGHT_BIT] = noiseRight; // RL4
      adcSrc[ENG_STD_BIT] = engineStdInt; // RL5
      adcSrc[ENG_AUX_BIT] = engineAuxInt; // RL5
   end

   // a read of either sticky register clears it and stops a repeating train
   assign ovfClear = regHit(regAddr, ADDR_OVF_STICKY, regRd); // RL2
   assign adcClear = regHit(regAddr, ADDR_ADC_STICKY, regRd); // RL2

   sticky_flags #(
      .MASK(OVF_MASK)
   ) ovfFlags (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .src(ovfSrc),
      .clearReq(ovfClear),
      .stickyOut(ovfSticky),
      .liveOut(ovfLive),
      .riseOut(ovfRise)
   );

   sticky_flags #(
      .MASK(ADC_MASK)
   ) adcFlags (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .src(adcSrc),
      .clearReq(adcClear),
      .stickyOut(adcSticky),
      .liveOut(adcLive),
      .riseOut(adcRise)
   );

   // fresh events of enabled sources, and the enabled data-available level, are ORed into one trigger
   always_comb begin
      intEvent = 1'b0;
      if (topReg.ctrl[CTRL_NOISE_EN_BIT] && ((adcRise & NOISE_MASK) != 8'h00)) begin // RL7
         intEvent = 1'b1;
      end
      if (topReg.ctrl[CTRL_ENG_EN_BIT] && (((adcRise & ENG_MASK) | ovfRise) != 8'h00)) begin // RL8
         intEvent = 1'b1;
      end
      if (topReg.ctrl[CTRL_DAV_EN_BIT] && dataAvail) begin // RL9 RL14
         intEvent = 1'b1;
      end
   end

   int_pulse_gen #(
      .PULSE_CYCLES(PULSE_CYCLES),
      .PERIOD_CYCLES(PERIOD_CYCLES)
   ) pulseGen (
      .clk_sys(clk_sys),
      .reset(reset),
      .clkEn(clkEn),
      .trigger(intEvent),
      .repeatMode(topReg.ctrl[CTRL_REPEAT_BIT]),
      .stopReq(ovfClear | adcClear),
      .pulseOut(pulseOut)
   );

   // register port: reads answer one cycle later, unmapped addresses read zero
   always_comb begin
      topNext = topReg;
      topNext.rdValid = regRd;
      if (regHit(regAddr, ADDR_INT_CTRL, regWr)) begin
         topNext.ctrl = regWdata & CTRL_MASK; // reserved control bits kept at reset value
      end
      if (regRd) begin
         case (regAddr)
            ADDR_OVF_STICKY: topNext.rdData = ovfSticky; // RL1
            ADDR_OVF_LIVE: topNext.rdData = ovfLive; // RL6
            ADDR_ADC_STICKY: topNext.rdData = adcSticky;
            ADDR_ADC_LIVE: topNext.rdData = adcLive; // RL6
            ADDR_INT_CTRL: topNext.rdData = topReg.ctrl;
            default: topNext.rdData = READ_UNMAPPED;
         endcase
      end
   end

   // clock enable low freezes everything, the pin included
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         topReg <= '{ctrl: CTRL_RESET, rdData: READ_UNMAPPED, rdValid: 1'b0};
      end else if (clkEn) begin
         topReg <= topNext;
      end
   end

   assign regRdata = topReg.rdData;
   assign regRdValid = topReg.rdValid;
   assign firstInterruptPin = pulseOut;

   sticky_read_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      clkEn && regRd && regAddr == ADDR_OVF_STICKY |=> regRdValid && regRdata == $past(ovfSticky))
      else $error("sticky overflow read returned wrong data");
   reserved_zero_a: assert property (@(posedge clk_sys) disable iff (reset) // RL1
      (ovfSticky & ~OVF_MASK) == 8'h00 && (adcSticky & ~ADC_MASK) == 8'h00)
      else $error("reserved flag bit set");
   noise_live_a: assert property (@(posedge clk_sys) disable iff (reset) // RL3
      clkEn && noiseLeft |=> adcLive[NOISE_LEFT_BIT])
      else $error("live left noise bit wrong");
   ctrl_write_a: assert property (@(posedge clk_sys) disable iff (reset) // RL7
      clkEn && regWr && regAddr == ADDR_INT_CTRL |=> topReg.ctrl == ($past(regWdata) & CTRL_MASK))
      else $error("control write not stored");
   masked_off_a: assert property (@(posedge clk_sys) disable iff (reset) // RL14
      topReg.ctrl[CTRL_NOISE_EN_BIT:CTRL_DAV_EN_BIT] == 4'h0 |-> !intEvent)
      else $error("disabled source triggered interrupt");

   // live overflow view follows the sources one enabled cycle late
   ovf_live_a: assert property (@(posedge clk_sys) disable iff (reset) // RL6
      clkEn
      |=> ovfLive == ($past(ovfSrc) & OVF_MASK))
      else $error("live overflow view wrong");

   // live event view follows the sources one enabled cycle late
   adc_live_a: assert property (@(posedge clk_sys) disable iff (reset) // RL6
      clkEn
      |=> adcLive == ($past(adcSrc) & ADC_MASK))
      else $error("live event view wrong");

   // reading the live copy must not eat a pending sticky overflow bit
   ovf_live_read_a: assert property (@(posedge clk_sys) disable iff (reset) // RL6
      clkEn && regRd && regAddr == ADDR_OVF_LIVE
      |=> (ovfSticky & $past(ovfSticky)) == $past(ovfSticky))
      else $error("live overflow read cleared a sticky bit");

   // reading the live copy must not eat a pending sticky event bit
   adc_live_read_a: assert property (@(posedge clk_sys) disable iff (reset) // RL6
      clkEn && regRd && regAddr == ADDR_ADC_LIVE
      |=> (adcSticky & $past(adcSticky)) == $past(adcSticky))
      else $error("live event read cleared a sticky bit");

   // fresh left overflow lands in its sticky bit
   left_ovf_set_a: assert property (@(posedge clk_sys) disable iff (reset) // RL1
      clkEn && ovfLeft && !ovfLive[OVF_LEFT_BIT]
      |=> ovfSticky[OVF_LEFT_BIT])
      else $error("left overflow flag not set");

   // fresh right overflow lands in its sticky bit
   right_ovf_set_a: assert property (@(posedge clk_sys) disable iff (reset) // RL1
      clkEn && ovfRight && !ovfLive[OVF_RIGHT_BIT]
      |=> ovfSticky[OVF_RIGHT_BIT])
      else $error("right overflow flag not set");

   // fresh shifter overflow lands in its sticky bit
   shift_ovf_set_a: assert property (@(posedge clk_sys) disable iff (reset) // RL1
      clkEn && ovfShifter && !ovfLive[OVF_SHIFT_BIT]
      |=> ovfSticky[OVF_SHIFT_BIT])
      else $error("shifter overflow flag not set");

   // a level that merely stays high must not set the flag again
   ovf_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      clkEn && !ovfClear && ovfRise == 8'h00
      |=> ovfSticky == $past(ovfSticky))
      else $error("overflow flags changed without event or read");

   // same for the event flags, so a stale level never re-arms them
   adc_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      clkEn && !adcClear && adcRise == 8'h00
      |=> adcSticky == $past(adcSticky))
      else $error("event flags changed without event or read");

   // the clearing read still hands back what stood before it
   adc_read_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      clkEn && regRd && regAddr == ADDR_ADC_STICKY
      |=> regRdValid && regRdata == $past(adcSticky))
      else $error("sticky event read returned wrong data");

   // a read with no fresh event leaves the event flags empty
   adc_cleared_a: assert property (@(posedge clk_sys) disable iff (reset) // RL2
      clkEn && adcClear && adcRise == 8'h00
      |=> adcSticky == 8'h00)
      else $error("sticky event flags not cleared by read");

   // left power above threshold reads zero in the live view
   noise_quiet_a: assert property (@(posedge clk_sys) disable iff (reset) // RL3
      clkEn && !noiseLeft
      |=> !adcLive[NOISE_LEFT_BIT])
      else $error("live left noise bit stuck high");

   // right power below threshold reads one in the live view
   right_noise_a: assert property (@(posedge clk_sys) disable iff (reset) // RL4
      clkEn && noiseRight
      |=> adcLive[NOISE_RIGHT_BIT])
      else $error("live right noise bit wrong");

   // right power above threshold reads zero in the live view
   right_quiet_a: assert property (@(posedge clk_sys) disable iff (reset) // RL4
      clkEn && !noiseRight
      |=> !adcLive[NOISE_RIGHT_BIT])
      else $error("live right noise bit stuck high");

   // fresh standard engine interrupt lands in its sticky bit
   eng_std_set_a: assert property (@(posedge clk_sys) disable iff (reset) // RL5
      clkEn && engineStdInt && !adcLive[ENG_STD_BIT]
      |=> adcSticky[ENG_STD_BIT])
      else $error("engine standard flag not set");

   // fresh auxiliary engine interrupt lands in its sticky bit
   eng_aux_set_a: assert property (@(posedge clk_sys) disable iff (reset) // RL5
      clkEn && engineAuxInt && !adcLive[ENG_AUX_BIT]
      |=> adcSticky[ENG_AUX_BIT])
      else $error("engine auxiliary flag not set");

   // enabled noise edges must reach the pulse generator
   noise_enable_a: assert property (@(posedge clk_sys) disable iff (reset) // RL7
      topReg.ctrl[CTRL_NOISE_EN_BIT] && (adcRise & NOISE_MASK) != 8'h00
      |-> intEvent)
      else $error("enabled noise event ignored");

   // enabled overflow edges must reach the pulse generator
   ovf_enable_a: assert property (@(posedge clk_sys) disable iff (reset) // RL8
      topReg.ctrl[CTRL_ENG_EN_BIT] && ovfRise != 8'h00
      |-> intEvent)
      else $error("enabled overflow event ignored");

   // enabled engine edges must reach the pulse generator
   eng_enable_a: assert property (@(posedge clk_sys) disable iff (reset) // RL8
      topReg.ctrl[CTRL_ENG_EN_BIT] && (adcRise & ENG_MASK) != 8'h00
      |-> intEvent)
      else $error("enabled engine event ignored");

   // data-available is a level, so every enabled cycle counts
   dav_enable_a: assert property (@(posedge clk_sys) disable iff (reset) // RL9
      topReg.ctrl[CTRL_DAV_EN_BIT] && dataAvail
      |-> intEvent)
      else $error("enabled data-available event ignored");

   // nothing but an enabled source may raise the trigger
   event_source_a: assert property (@(posedge clk_sys) disable iff (reset) // RL14
      intEvent
      |-> ((topReg.ctrl[CTRL_NOISE_EN_BIT] && (adcRise & NOISE_MASK) != 8'h00)
         || (topReg.ctrl[CTRL_ENG_EN_BIT] && ((adcRise & ENG_MASK) | ovfRise) != 8'h00)
         || (topReg.ctrl[CTRL_DAV_EN_BIT] && dataAvail)))
      else $error("interrupt event without an enabled source");

   // a sticky read with no new event ends a train that is in its low phase
   train_stop_a: assert property (@(posedge clk_sys) disable iff (reset) // RL11
      clkEn && (ovfClear || adcClear) && !intEvent && !firstInterruptPin
      |=> !firstInterruptPin)
      else $error("pulse train kept running after a flag read");

   // the enables move only on a write, so a stray strobe cannot unmask a source
   ctrl_hold_a: assert property (@(posedge clk_sys) disable iff (reset) // RL7
      clkEn && !(regWr && regAddr == ADDR_INT_CTRL)
      |=> topReg.ctrl == $past(topReg.ctrl))
      else $error("control changed without a write");
endmodule
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the register strobe port; drives just after an edge, one strobe per access
module host_model
   import adc_int_pkg::*;
(
   input wire logic clk_sys,
   input wire logic [7:0] regRdata,
   input wire logic regRdValid,
   output logic [7:0] regAddr,
   output logic regWr,
   output logic regRd,
   output logic [7:0] regWdata
);
   // quiet bus at time zero
   initial begin
      regAddr = 8'h00;
      regWr = 1'b0;
      regRd = 1'b0;
      regWdata = 8'h00;
   end

   // only the control register is ever written; released lines show inverted values, not stale ones
   task automatic wr(input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      regAddr = ADDR_INT_CTRL;
      regWdata = (d & CTRL_MASK) | (CTRL_RESET & ~CTRL_MASK);
      regWr = 1'b1;
      @(posedge clk_sys);
      #1;
      regWr = 1'b0;
      regAddr = ~regAddr;
      regWdata = ~regWdata;
   endtask

   // data is taken only while the one-cycle valid pulse stands, else unknown so the compare fails
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_sys);
      #1;
      regAddr = a;
      regRd = 1'b1;
      @(posedge clk_sys);
      #1;
      d = (regRdValid === 1'b1) ? regRdata : 8'hXX;
      regRd = 1'b0;
      regAddr = ~a;
   endtask
endmodule
`default_nettype wire

// ===== adc_interrupt_flags_first_interrupt_pin_test.sv
`timescale 1ns/1ps
`default_nettype none
module adc_interrupt_flags_first_interrupt_pin_test;
   import adc_int_pkg::*;
   // short pulse timing keeps the run small; expectations follow from these
   localparam int unsigned P_PULSE = 4;
   localparam int unsigned P_PERIOD = 8;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] srcVec = 8'h00;
   wire logic [7:0] regAddr, regWdata, regRdata;
   wire logic regWr, regRd, regRdValid, pin;
   int error_cnt = 0;
   int n_tests = 0;
   int w, l, i;
   logic [7:0] got, ovfExp, adcExp, c, s;
   logic en;
   logic clkEn = 1'b1;
   // rows: control value, then sources {ovfL,ovfR,ovfShift,noiseL,noiseR,engStd,engAux,dataAvail}
   logic [15:0] rows [13] = '{16'h0480, 16'h0440, 16'h0420, 16'h0080, 16'h1010, 16'h1008, 16'h0410,
                              16'h0404, 16'h0402, 16'h1004, 16'h0201, 16'h0001, 16'h1622};
   logic [7:0] addrs [6] = '{ADDR_OVF_STICKY, ADDR_OVF_LIVE, ADDR_ADC_STICKY, ADDR_ADC_LIVE, ADDR_INT_CTRL, 8'h2C};

   // free-running system clock
   always #5 clk_sys = ~clk_sys;

   adc_interrupt_flags_first_interrupt_pin #(.PULSE_CYCLES(P_PULSE), .PERIOD_CYCLES(P_PERIOD)) u_dut (
      .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .regAddr(regAddr), .regWr(regWr), .regRd(regRd),
      .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid), .ovfLeft(srcVec[7]),
      .ovfRight(srcVec[6]), .ovfShifter(srcVec[5]), .noiseLeft(srcVec[4]), .noiseRight(srcVec[3]),
      .engineStdInt(srcVec[2]), .engineAuxInt(srcVec[1]), .dataAvail(srcVec[0]), .firstInterruptPin(pin));

   host_model u_host (.clk_sys(clk_sys), .regRdata(regRdata), .regRdValid(regRdValid), .regAddr(regAddr),
      .regWr(regWr), .regRd(regRd), .regWdata(regWdata));

   task automatic tick();
      @(posedge clk_sys);
      #1;
   endtask

   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // waits a few cycles for the pin to rise, then counts its high cycles; 0 if it never rose
   task automatic pulse_width(output int n);
      int k;
      n = 0;
      for (k = 0; k < 6 && pin !== 1'b1; k++) tick();
      while (pin === 1'b1 && n < 40) begin
         n++;
         tick();
      end
   endtask

   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // watchdog: the whole sequence needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk_sys);
      error_cnt++;
      $display("wrong value at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   // main sequence
   initial begin
      repeat (20) @(posedge clk_sys);
      #1;
      reset = 1'b0;
      for (i = 0; i < 6; i++) begin
         u_host.rd(addrs[i], got);
         chk(got, 8'h00);
      end
      u_host.wr(8'hFF);
      u_host.rd(ADDR_INT_CTRL, got);
      chk(got, CTRL_MASK);
      // one source pattern per row: pin width, live view, sticky view, clear-on-read
      for (i = 0; i < 13; i++) begin
         c = rows[i][15:8];
         s = rows[i][7:0];
         en = (c[2] & (|s[7:5] | |s[2:1])) | (c[4] & |s[4:3]) | (c[1] & s[0]);
         ovfExp = {4'h0, s[7:5], 1'b0};
         adcExp = {1'b0, s[4:3], s[2:1], 3'b000};
         u_host.wr(c);
         srcVec = s;
         pulse_width(w);
         chk(8'(w), en ? 8'(P_PULSE) : 8'h00);
         u_host.rd(ADDR_OVF_LIVE, got);
         chk(got, ovfExp);
         u_host.rd(ADDR_ADC_LIVE, got);
         chk(got, adcExp);
         srcVec = 8'h00;
         u_host.rd(ADDR_OVF_STICKY, got);
         chk(got, ovfExp);
         u_host.rd(ADDR_ADC_STICKY, got);
         chk(got, adcExp);
         u_host.rd(ADDR_OVF_STICKY, got);
         chk(got, 8'h00);
         repeat (12) tick();
      end
      // held source: one pulse only, no re-set after a clearing read, live copy unaffected
      u_host.wr(8'h04);
      srcVec = 8'h40;
      pulse_width(w);
      chk(8'(w), 8'(P_PULSE));
      u_host.rd(ADDR_OVF_STICKY, got);
      chk(got, 8'h04);
      pulse_width(w);
      chk(8'(w), 8'h00);
      u_host.rd(ADDR_OVF_STICKY, got);
      chk(got, 8'h00);
      u_host.rd(ADDR_OVF_LIVE, got);
      chk(got, 8'h04);
      srcVec = 8'h00;
      // repeat mode: pulse train until a sticky read stops it
      u_host.wr(8'h05);
      srcVec = 8'h80;
      tick();
      srcVec = 8'h00;
      pulse_width(w);
      chk(8'(w), 8'(P_PULSE));
      l = 0;
      while (pin === 1'b0 && l < 40) begin
         l++;
         tick();
      end
      chk(8'(l), 8'(P_PERIOD - P_PULSE));
      pulse_width(w);
      chk(8'(w), 8'(P_PULSE));
      u_host.rd(ADDR_OVF_STICKY, got);
      chk(got, 8'h08);
      l = 0;
      repeat (2 * P_PERIOD) begin
         tick();
         if (pin === 1'b1) l++;
      end
      chk(8'(l), 8'h00);
      // clock enable low for three cycles in mid-pulse stretches the pulse by three
      u_host.wr(8'h04);
      srcVec = 8'h04;
      tick();
      clkEn = 1'b0;
      l = 0;
      repeat (3) begin
         if (pin === 1'b1) l++;
         tick();
      end
      clkEn = 1'b1;
      srcVec = 8'h00;
      pulse_width(w);
      chk(8'(l + w), 8'(P_PULSE + 3));
      // reset in mid-pulse clears pin and control
      u_host.wr(8'h04);
      srcVec = 8'h20;
      repeat (3) tick();
      reset = 1'b1;
      repeat (2) tick();
      reset = 1'b0;
      chk({7'h00, pin}, 8'h00);
      srcVec = 8'h00;
      u_host.rd(ADDR_INT_CTRL, got);
      chk(got, CTRL_RESET);
      tally_and_finish();
   end
endmodule
`default_nettype wire
